// [reset_startup_pkg.sv]
// constants for the reset pin and clock start-up block
package reset_startup_pkg;
   // register byte addresses
   localparam logic [7:0] ADDR_SYSTEM_OPTIONS = 8'h00;
   localparam logic [7:0] ADDR_RESET_CAUSE = 8'h04;
   localparam logic [7:0] ADDR_CAUSE_MASK = 8'h08;
   localparam logic [7:0] ADDR_DEBUG_FORCE = 8'h0c;
   localparam logic [7:0] ADDR_CLOCK_CTRL = 8'h10;
   localparam logic [7:0] ADDR_PORT_CTRL = 8'h14;
   // system options fields
   localparam int OPT_RESET_PIN_EN = 0;
   localparam int OPT_DEBUG_PIN_EN = 1;
   localparam logic [1:0] OPT_RESET_VALUE = 2'h2;
   // reset cause fields
   localparam int CAUSE_W = 4;
   localparam int CAUSE_POWER_ON = 0;
   localparam int CAUSE_PIN = 1;
   localparam int CAUSE_WATCHDOG = 2;
   localparam int CAUSE_DEBUG_FORCE = 3;
   localparam logic [3:0] CAUSE_RESET_VALUE = 4'h1;
   localparam logic [3:0] MASK_RESET_VALUE = 4'h0;
   // debug force field
   localparam int FORCE_BIT = 0;
   // clock control fields
   localparam int CLK_EXTERNAL_SEL = 0;
   localparam int CLK_WDOG_LPO_SEL = 1;
   localparam int CLK_RTC_LPO_SEL = 2;
   localparam logic [2:0] CLK_RESET_VALUE = 3'h0;
   // port control fields
   localparam int PORT_DATA = 0;
   localparam int PORT_DIR = 1;
   localparam int PORT_LEVEL = 2;
   localparam logic [1:0] PORT_RESET_VALUE = 2'h0;
   // timing
   localparam int CORE_PERIOD_NS = 5;
   localparam int BUS_DIVIDE = 2;
   localparam int PIN_DRIVE_BUS_CYCLES = 66;
   localparam int PIN_DRIVE_CYCLES = PIN_DRIVE_BUS_CYCLES * BUS_DIVIDE;
   localparam int POR_HOLD_CYCLES = 16;
   localparam int COUNT_W = 8;
   localparam int LPO_PERIOD_NS = 1000000;
   localparam int LPO_DIV_CYCLES = LPO_PERIOD_NS / CORE_PERIOD_NS;
   localparam int LPO_COUNT_W = 18;
endpackage

// [pin_sync.sv]
// two-flop synchroniser for pin levels
`timescale 1ns/10ps
module pin_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '1
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= INIT;
         sync_q <= INIT;
      end else begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end

   assign sync_out = sync_q;
endmodule

// [tick_divider.sv]
// free-running divider giving a one-cycle tick every div_cycles
`timescale 1ns/10ps
module tick_divider #(
   parameter int CW = 18
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [CW-1:0] div_cycles,
   output logic tick
);
   logic [CW-1:0] count_q;
   logic [CW-1:0] count_d;
   logic tick_q;
   logic wrap;

   assign wrap = (count_q >= div_cycles - CW'(1));
   assign count_d = wrap ? '0 : count_q + CW'(1);

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         count_q <= '0;
         tick_q <= 1'b0;
      end else begin
         count_q <= count_d;
         tick_q <= wrap;
      end
   end

   assign tick = tick_q;
endmodule

// [reset_pin_and_clock_startup.sv]
// reset pin control, reset cause, debug mode entry and clock start-up
//
// The implementer's own choices: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
// Functional notes
// - after power-on pin is port bit
// - enable bit makes open-drain reset pin
// - external low on enabled pin resets
// - non-power-on reset drives enabled reset pin 66 bus cycles
// - reset cause recorded in cause register
// - pin reset always ends in user mode
// - debug mode via power-on or forced reset
// - internal clock selected after every reset
// - bus clock is half generator output
// - independent 1 kHz low-power tick
// - debug pin enable set after every reset
// - floating mode pin gives normal mode
module reset_pin_and_clock_startup #(
   parameter int LPO_DIV = reset_startup_pkg::LPO_DIV_CYCLES
) (
   input wire logic core_clk,
   input wire logic rst_n,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // shared reset / port pin
   input wire logic port_a_bit_five_in,
   output logic port_a_bit_five_out,
   output logic port_a_bit_five_oe_n,
   // mode select pin, sampled only
   input wire logic mode_select_pin_in,
   // internal requests, same clock
   input wire logic watchdog_reset_req,
   input wire logic debug_access,
   // system outputs
   output logic sys_rst_n,
   output logic background_debug_mode,
   output logic debug_pin_enable,
   output logic clock_internal_sel,
   output logic bus_clk,
   output logic low_power_osc_tick,
   output logic watchdog_lpo_sel,
   output logic rtc_lpo_sel,
   output logic irq
);
   // ==========================================================
   // types and declarations
   typedef enum logic [2:0] {
      ST_POWER_ON,
      ST_DRIVE,
      ST_RELEASE,
      ST_RUN
   } seq_state_t;

   seq_state_t state_q, state_d;
   logic [reset_startup_pkg::COUNT_W-1:0] count_q, count_d;
   logic [1:0] options_q;
   logic [reset_startup_pkg::CAUSE_W-1:0] cause_q, cause_d;
   logic [reset_startup_pkg::CAUSE_W-1:0] mask_q;
   logic [reset_startup_pkg::CAUSE_W-1:0] kind_q, kind_d;
   logic [2:0] clk_ctrl_q;
   logic clk_int_q;
   logic [1:0] port_q;
   logic [31:0] prdata_q;
   logic pready_q;
   logic pslverr_q;
   logic pin_out_q;
   logic pin_oe_n_q;
   logic sys_rst_n_q;
   logic debug_mode_q;
   logic bus_clk_q;
   logic lpo_tick_q;
   logic irq_q;
   logic pin_level;
   logic mode_level;
   logic lpo_tick_raw;

   // ==========================================================
   // pin synchronisers
   pin_sync #(
      .W(1),
      .INIT(1'b1)
   ) u_pin_sync (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .async_in(port_a_bit_five_in),
      .sync_out(pin_level)
   );

   pin_sync #(
      .W(1),
      .INIT(1'b1)
   ) u_mode_sync (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .async_in(mode_select_pin_in),
      .sync_out(mode_level)
   );

   // ==========================================================
   // low-power 1 kHz tick
   tick_divider #(
      .CW(reset_startup_pkg::LPO_COUNT_W)
   ) u_lpo_div (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .div_cycles(reset_startup_pkg::LPO_COUNT_W'(LPO_DIV)),
      .tick(lpo_tick_raw)
   );

   // ==========================================================
   // apb decode
   wire setup_phase = psel & ~penable;
   wire access_done = psel & penable & pready_q;
   wire wr_en = access_done & pwrite;
   wire rd_en = access_done & ~pwrite;
   wire sel_options = (paddr == reset_startup_pkg::ADDR_SYSTEM_OPTIONS);
   wire sel_cause = (paddr == reset_startup_pkg::ADDR_RESET_CAUSE);
   wire sel_mask = (paddr == reset_startup_pkg::ADDR_CAUSE_MASK);
   wire sel_force = (paddr == reset_startup_pkg::ADDR_DEBUG_FORCE);
   wire sel_clock = (paddr == reset_startup_pkg::ADDR_CLOCK_CTRL);
   wire sel_port = (paddr == reset_startup_pkg::ADDR_PORT_CTRL);
   wire addr_hit = sel_options | sel_cause | sel_mask | sel_force | sel_clock | sel_port;
   wire reset_pin_mode = options_q[reset_startup_pkg::OPT_RESET_PIN_EN];
   wire in_run = (state_q == ST_RUN);

   // reset triggers while running
   wire pin_trigger = in_run & reset_pin_mode & ~pin_level;
   wire wdog_trigger = in_run & watchdog_reset_req;
   wire force_trigger = in_run & wr_en & sel_force & debug_access
      & pwdata[reset_startup_pkg::FORCE_BIT];
   wire any_trigger = pin_trigger | wdog_trigger | force_trigger;

   wire [31:0] read_mux =
      sel_options ? {30'h0, options_q} :
      sel_cause ? {28'h0, cause_q} :
      sel_mask ? {28'h0, mask_q} :
      sel_clock ? {29'h0, clk_ctrl_q} :
      sel_port ? {29'h0, pin_level, port_q} :
      32'h0;

   // ==========================================================
   // reset sequencer
   always_comb begin
      state_d = state_q;
      count_d = count_q;
      kind_d = kind_q;
      unique case (state_q)
         ST_POWER_ON: begin
            if (count_q == reset_startup_pkg::COUNT_W'(reset_startup_pkg::POR_HOLD_CYCLES - 1)) begin
               state_d = ST_RUN;
               count_d = '0;
            end else begin
               count_d = count_q + reset_startup_pkg::COUNT_W'(1);
            end
         end
         ST_DRIVE: begin
            if (count_q == reset_startup_pkg::COUNT_W'(reset_startup_pkg::PIN_DRIVE_CYCLES - 1)) begin
               state_d = ST_RELEASE;
               count_d = '0;
            end else begin
               count_d = count_q + reset_startup_pkg::COUNT_W'(1);
            end
         end
         ST_RELEASE: begin
            // wait out the pin's own low pulse before running again
            if (!reset_pin_mode || pin_level) begin
               state_d = ST_RUN;
            end
         end
         ST_RUN: begin
            if (any_trigger) begin
               state_d = ST_DRIVE;
               count_d = '0;
               kind_d = '0;
               kind_d[reset_startup_pkg::CAUSE_PIN] = pin_trigger;
               kind_d[reset_startup_pkg::CAUSE_WATCHDOG] = ~pin_trigger & wdog_trigger;
               kind_d[reset_startup_pkg::CAUSE_DEBUG_FORCE] = ~pin_trigger & ~wdog_trigger;
            end
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= ST_POWER_ON;
         count_q <= '0;
         kind_q <= '0;
      end else begin
         state_q <= state_d;
         count_q <= count_d;
         kind_q <= kind_d;
      end
   end

   // ==========================================================
   // reset cause: set by new reset, cleared by read, set wins
   wire cause_rd_clr = rd_en & sel_cause;
   wire reset_done = (state_q != ST_RUN) & (state_d == ST_RUN);

   always_comb begin
      cause_d = cause_rd_clr ? '0 : cause_q;
      if (in_run && any_trigger) begin
         cause_d = kind_d;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cause_q <= reset_startup_pkg::CAUSE_RESET_VALUE;
      end else begin
         cause_q <= cause_d;
      end
   end

   // ==========================================================
   // system options and mode capture
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         options_q <= reset_startup_pkg::OPT_RESET_VALUE;
      end else if (in_run && any_trigger) begin
         // reset pin function survives every reset but power-on
         options_q[reset_startup_pkg::OPT_DEBUG_PIN_EN] <= 1'b1;
      end else if (wr_en && sel_options) begin
         options_q[reset_startup_pkg::OPT_DEBUG_PIN_EN] <=
            pwdata[reset_startup_pkg::OPT_DEBUG_PIN_EN];
         if (pwdata[reset_startup_pkg::OPT_RESET_PIN_EN]) begin
            options_q[reset_startup_pkg::OPT_RESET_PIN_EN] <= 1'b1;
         end
      end
   end

   // debug mode only from power-on or forced reset with mode pin low
   wire mode_entry = (state_q == ST_POWER_ON) | kind_q[reset_startup_pkg::CAUSE_DEBUG_FORCE];

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         debug_mode_q <= 1'b0;
      end else if (reset_done) begin
         debug_mode_q <= mode_entry & ~mode_level;
      end
   end

   // ==========================================================
   // other software registers
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         mask_q <= reset_startup_pkg::MASK_RESET_VALUE;
      end else if (wr_en && sel_mask) begin
         mask_q <= pwdata[reset_startup_pkg::CAUSE_W-1:0];
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         clk_ctrl_q <= reset_startup_pkg::CLK_RESET_VALUE;
         clk_int_q <= ~reset_startup_pkg::CLK_RESET_VALUE[reset_startup_pkg::CLK_EXTERNAL_SEL];
      end else if (in_run && any_trigger) begin
         clk_ctrl_q <= reset_startup_pkg::CLK_RESET_VALUE;
         clk_int_q <= ~reset_startup_pkg::CLK_RESET_VALUE[reset_startup_pkg::CLK_EXTERNAL_SEL];
      end else if (wr_en && sel_clock) begin
         clk_ctrl_q <= pwdata[2:0];
         clk_int_q <= ~pwdata[reset_startup_pkg::CLK_EXTERNAL_SEL];
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         port_q <= reset_startup_pkg::PORT_RESET_VALUE;
      end else if (in_run && any_trigger) begin
         port_q <= reset_startup_pkg::PORT_RESET_VALUE;
      end else if (wr_en && sel_port) begin
         port_q <= pwdata[1:0];
      end
   end

   // ==========================================================
   // apb answer: no wait states, error on unmapped address
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0;
      end else begin
         pready_q <= setup_phase;
         pslverr_q <= setup_phase & ~addr_hit;
         if (setup_phase) begin
            prdata_q <= pwrite ? 32'h0 : read_mux;
         end
      end
   end

   // ==========================================================
   // pin drive, system reset, clocks and interrupt
   // registered output: low exactly while the state is drive, in reset pin mode
   wire driving = (state_d == ST_DRIVE);

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_out_q <= 1'b0;
         pin_oe_n_q <= 1'b1;
         sys_rst_n_q <= 1'b0;
         bus_clk_q <= 1'b0;
         lpo_tick_q <= 1'b0;
         irq_q <= 1'b0;
      end else begin
         if (reset_pin_mode) begin
            // open drain: only ever pulls low
            pin_out_q <= 1'b0;
            pin_oe_n_q <= ~driving;
         end else begin
            pin_out_q <= port_q[reset_startup_pkg::PORT_DATA];
            pin_oe_n_q <= ~port_q[reset_startup_pkg::PORT_DIR];
         end
         sys_rst_n_q <= (state_d == ST_RUN);
         bus_clk_q <= ~bus_clk_q;
         lpo_tick_q <= lpo_tick_raw;
         irq_q <= |(cause_d & mask_q);
      end
   end

   // ==========================================================
   // outputs
   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign port_a_bit_five_out = pin_out_q;
   assign port_a_bit_five_oe_n = pin_oe_n_q;
   assign sys_rst_n = sys_rst_n_q;
   assign background_debug_mode = debug_mode_q;
   assign debug_pin_enable = options_q[reset_startup_pkg::OPT_DEBUG_PIN_EN];
   assign clock_internal_sel = clk_int_q;
   assign bus_clk = bus_clk_q;
   assign low_power_osc_tick = lpo_tick_q;
   assign watchdog_lpo_sel = clk_ctrl_q[reset_startup_pkg::CLK_WDOG_LPO_SEL];
   assign rtc_lpo_sel = clk_ctrl_q[reset_startup_pkg::CLK_RTC_LPO_SEL];
   assign irq = irq_q;
endmodule

// [reset_pin_and_clock_startup_assertions.sv]
// checker for reset pin and clock start-up behaviour
`timescale 1ns/10ps
module reset_startup_checker #(
   parameter int LPO_DIV = 20
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic port_a_bit_five_in,
   input wire logic port_a_bit_five_out,
   input wire logic port_a_bit_five_oe_n,
   input wire logic sys_rst_n,
   input wire logic background_debug_mode,
   input wire logic debug_pin_enable,
   input wire logic clock_internal_sel,
   input wire logic bus_clk,
   input wire logic low_power_osc_tick
);
   logic mode_q, pin_q, lpo_seen_q;
   logic [8:0] drv_q;
   logic [17:0] lpo_q;
   wire opt_wr = psel && penable && pready && pwrite && paddr == reset_startup_pkg::ADDR_SYSTEM_OPTIONS;
   wire pin_en_wr = opt_wr && pwdata[reset_startup_pkg::OPT_RESET_PIN_EN];
   // ==========
   // helper state
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         mode_q <= 1'b0;
         pin_q <= 1'b0;
         drv_q <= 9'h0;
         lpo_q <= 18'h0;
         lpo_seen_q <= 1'b0;
      end else begin
         mode_q <= mode_q || pin_en_wr;
         pin_q <= sys_rst_n ? (mode_q && !port_a_bit_five_in) : pin_q;
         drv_q <= (!port_a_bit_five_oe_n && !sys_rst_n) ? drv_q + 9'h1 : 9'h0;
         lpo_q <= low_power_osc_tick ? 18'h0 : lpo_q + 18'h1;
         lpo_seen_q <= lpo_seen_q || low_power_osc_tick;
      end
   end
   // ==========
   // properties
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   property p_port; !mode_q && !sys_rst_n && !$past(sys_rst_n) |-> port_a_bit_five_oe_n; endproperty
   a_port: assert property (p_port) else $error("port mode pin driven in reset");
   property p_od; mode_q && $past(mode_q) |-> !port_a_bit_five_out; endproperty
   a_od: assert property (p_od) else $error("reset pin drives high");
   property p_pin; mode_q && sys_rst_n ##0 !port_a_bit_five_in [*2] |-> ##[0:3] !sys_rst_n; endproperty
   a_pin: assert property (p_pin) else $error("pin low gave no reset");
   property p_drive; $rose(port_a_bit_five_oe_n) && drv_q != 9'h0 |-> drv_q == 9'(reset_startup_pkg::PIN_DRIVE_CYCLES);
   endproperty
   a_drive: assert property (p_drive) else $error("pin drive length wrong");
   property p_user; $rose(sys_rst_n) && pin_q |=> !background_debug_mode [*3]; endproperty
   a_user: assert property (p_user) else $error("pin reset entered debug mode");
   property p_clk; !sys_rst_n && !$past(sys_rst_n) |-> clock_internal_sel; endproperty
   a_clk: assert property (p_clk) else $error("internal clock not selected");
   property p_bus_half; $past(rst_n) |-> bus_clk != $past(bus_clk); endproperty
   a_bus_half: assert property (p_bus_half) else $error("bus clock not half rate");
   property p_lpo; low_power_osc_tick && lpo_seen_q |-> lpo_q == 18'(LPO_DIV - 1); endproperty
   a_lpo: assert property (p_lpo) else $error("low power tick period wrong");
   property p_dbg_pin; $rose(sys_rst_n) |-> debug_pin_enable; endproperty
   a_dbg_pin: assert property (p_dbg_pin) else $error("debug pin enable clear after reset");
   c_pin_reset: cover property ($rose(sys_rst_n) && pin_q);
   c_debug_mode: cover property ($rose(background_debug_mode));
   c_drive: cover property ($rose(port_a_bit_five_oe_n) && drv_q != 9'h0);
endmodule
bind reset_pin_and_clock_startup reset_startup_checker #(.LPO_DIV(LPO_DIV)) chk (.core_clk, .rst_n, .psel,
   .penable, .pwrite, .paddr, .pwdata, .pready, .port_a_bit_five_in, .port_a_bit_five_out, .port_a_bit_five_oe_n,
   .sys_rst_n, .background_debug_mode, .debug_pin_enable, .clock_internal_sel, .bus_clk, .low_power_osc_tick);

// [reset_pod_model.sv]
// reset switch and debug pod on the shared pins
`timescale 1ns/10ps
module reset_pod_model (
   input wire logic pin_out,
   input wire logic pin_oe_n,
   input wire logic press,
   input wire logic hold_ms,
   output logic pin_level,
   output logic ms_level
);
   // ==========
   // open-drain wire with pull-up
   assign pin_level = (press || (!pin_oe_n && !pin_out)) ? 1'b0 : pin_oe_n ? 1'b1 : pin_out;
   // released mode pin floats up
   assign ms_level = hold_ms ? 1'b0 : 1'b1;
endmodule

// [reset_pin_and_clock_startup_bench.sv]
// bench for reset pin and clock start-up block
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin error_cnt++; $display("Error %s exp %0h got %0h", nm, e, g); end end
module reset_pin_and_clock_startup_bench;
   logic core_clk, rst_n, psel, penable, pwrite, pready, pslverr, press, hold_ms, rerr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rdat;
   logic port_a_bit_five_in, port_a_bit_five_out, port_a_bit_five_oe_n, mode_select_pin_in;
   logic watchdog_reset_req, debug_access, sys_rst_n, background_debug_mode, debug_pin_enable;
   logic clock_internal_sel, bus_clk, low_power_osc_tick, watchdog_lpo_sel, rtc_lpo_sel, irq;
   int error_cnt = 0;
   int n_compared = 0;
   int cycles = 0;
   int n;
   reset_pin_and_clock_startup #(.LPO_DIV(20)) dut (.core_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .port_a_bit_five_in, .port_a_bit_five_out, .port_a_bit_five_oe_n,
      .mode_select_pin_in, .watchdog_reset_req, .debug_access, .sys_rst_n, .background_debug_mode,
      .debug_pin_enable, .clock_internal_sel, .bus_clk, .low_power_osc_tick, .watchdog_lpo_sel, .rtc_lpo_sel, .irq);
   reset_pod_model pod (.pin_out(port_a_bit_five_out), .pin_oe_n(port_a_bit_five_oe_n), .press, .hold_ms,
      .pin_level(port_a_bit_five_in), .ms_level(mode_select_pin_in));
   // ==========
   // helpers
   task automatic end_sim();
      $display("compared %0d errors %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do begin
         @(posedge core_clk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      `CHK("pready", 1'b1, pready)
   endtask
   task automatic wait_rst(input logic v);
      int k;
      k = 0;
      while (sys_rst_n !== v && k < 600) begin
         @(posedge core_clk);
         k++;
      end
      `CHK("sys_rst_n", v, sys_rst_n)
   endtask
   task automatic por();
      rst_n <= 1'b0;
      repeat (5) @(posedge core_clk);
      rst_n <= 1'b1;
      wait_rst(1'b1);
   endtask
   // counts cycles the device pulls the pin low
   task automatic drv_len();
      int k;
      k = 0;
      n = 0;
      while (port_a_bit_five_oe_n !== 1'b0 && k < 20) begin
         @(posedge core_clk);
         k++;
      end
      press <= 1'b0;
      while (port_a_bit_five_oe_n === 1'b0 && n < 300) begin
         @(posedge core_clk);
         n++;
      end
   endtask
   // ==========
   // scenarios
   task automatic t_por();
      logic b;
      b = bus_clk;
      @(posedge core_clk);
      `CHK("bus clk", ~b, bus_clk)
      n = 0;
      repeat (40) begin
         @(posedge core_clk);
         n += low_power_osc_tick;
      end
      `CHK("lpo ticks", 2, n)
      apb(1'b0, reset_startup_pkg::ADDR_RESET_CAUSE, 32'h0);
      `CHK("cause", reset_startup_pkg::CAUSE_RESET_VALUE, rdat[3:0])
      apb(1'b0, reset_startup_pkg::ADDR_SYSTEM_OPTIONS, 32'h0);
      `CHK("options", reset_startup_pkg::OPT_RESET_VALUE, rdat[1:0])
      apb(1'b0, reset_startup_pkg::ADDR_CLOCK_CTRL, 32'h0);
      `CHK("clk ctrl", reset_startup_pkg::CLK_RESET_VALUE, rdat[2:0])
      `CHK("oe_n", 1'b1, port_a_bit_five_oe_n)
      `CHK("clk int", 1'b1, clock_internal_sel)
      `CHK("dbg pin", 1'b1, debug_pin_enable)
      apb(1'b0, 8'h40, 32'h0);
      `CHK("slverr", 1'b1, rerr)
      `CHK("bad rdata", 32'h0, rdat)
   endtask
   task automatic t_modes();
      for (int i = 1; i >= 0; i--) begin
         hold_ms <= i[0];
         por();
         `CHK("bdm", i[0], background_debug_mode)
      end
   endtask
   task automatic t_port();
      press <= 1'b1;
      repeat (10) @(posedge core_clk);
      apb(1'b0, reset_startup_pkg::ADDR_PORT_CTRL, 32'h0);
      `CHK("port level", 1'b0, rdat[reset_startup_pkg::PORT_LEVEL])
      `CHK("sys_rst_n", 1'b1, sys_rst_n)
      press <= 1'b0;
      apb(1'b1, reset_startup_pkg::ADDR_PORT_CTRL, 32'h3);
      repeat (2) @(posedge core_clk);
      `CHK("port oe_n", 1'b0, port_a_bit_five_oe_n)
      `CHK("port out", 1'b1, port_a_bit_five_out)
      apb(1'b1, reset_startup_pkg::ADDR_PORT_CTRL, 32'h0);
   endtask
   task automatic t_force();
      for (int i = 1; i >= 0; i--) begin
         hold_ms <= i[0];
         debug_access <= 1'b1;
         apb(1'b1, reset_startup_pkg::ADDR_DEBUG_FORCE, 32'h1);
         debug_access <= 1'b0;
         wait_rst(1'b0);
         wait_rst(1'b1);
         `CHK("force bdm", i[0], background_debug_mode)
         apb(1'b0, reset_startup_pkg::ADDR_RESET_CAUSE, 32'h0);
         `CHK("force cause", 4'h1 << reset_startup_pkg::CAUSE_DEBUG_FORCE, rdat[3:0])
      end
      hold_ms <= 1'b0;
   endtask
   task automatic t_pin();
      apb(1'b1, reset_startup_pkg::ADDR_CLOCK_CTRL, 32'h7);
      @(posedge core_clk);
      `CHK("clk int", 1'b0, clock_internal_sel)
      `CHK("wdog lpo", 1'b1, watchdog_lpo_sel)
      `CHK("rtc lpo", 1'b1, rtc_lpo_sel)
      apb(1'b1, reset_startup_pkg::ADDR_SYSTEM_OPTIONS, 32'h1);
      hold_ms <= 1'b1;
      press <= 1'b1;
      drv_len();
      `CHK("pin drive", reset_startup_pkg::PIN_DRIVE_CYCLES, n)
      wait_rst(1'b1);
      `CHK("pin bdm", 1'b0, background_debug_mode)
      `CHK("clk int", 1'b1, clock_internal_sel)
      apb(1'b0, reset_startup_pkg::ADDR_RESET_CAUSE, 32'h0);
      `CHK("pin cause", 4'h1 << reset_startup_pkg::CAUSE_PIN, rdat[3:0])
      apb(1'b1, reset_startup_pkg::ADDR_SYSTEM_OPTIONS, 32'h0);
      apb(1'b0, reset_startup_pkg::ADDR_SYSTEM_OPTIONS, 32'h0);
      `CHK("pin en", 1'b1, rdat[reset_startup_pkg::OPT_RESET_PIN_EN])
      hold_ms <= 1'b0;
   endtask
   task automatic t_wdog();
      watchdog_reset_req <= 1'b1;
      @(posedge core_clk);
      watchdog_reset_req <= 1'b0;
      drv_len();
      `CHK("wdog drive", reset_startup_pkg::PIN_DRIVE_CYCLES, n)
      wait_rst(1'b1);
      `CHK("dbg pin", 1'b1, debug_pin_enable)
      apb(1'b1, reset_startup_pkg::ADDR_CAUSE_MASK, 32'h0);
      @(posedge core_clk);
      `CHK("irq masked", 1'b0, irq)
      apb(1'b1, reset_startup_pkg::ADDR_CAUSE_MASK, 32'hf);
      repeat (2) @(posedge core_clk);
      `CHK("irq", 1'b1, irq)
      apb(1'b0, reset_startup_pkg::ADDR_RESET_CAUSE, 32'h0);
      `CHK("wdog cause", 4'h1 << reset_startup_pkg::CAUSE_WATCHDOG, rdat[3:0])
      @(posedge core_clk);
      `CHK("irq cleared", 1'b0, irq)
   endtask
   // ==========
   // clock, timeout and sequence
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 5000) begin
         error_cnt++;
         end_sim();
      end
   end
   initial begin
      {rst_n, psel, penable, pwrite, press, hold_ms, watchdog_reset_req, debug_access} = '0;
      paddr = 8'h00;
      pwdata = 32'h0;
      por();
      t_por();
      t_modes();
      t_port();
      t_force();
      t_pin();
      t_wdog();
      end_sim();
   end
endmodule
